// ==== inc/twe_defines.svh ====
// constants and timing counts of the two-wire eeprom bus core
// Functional notes
// - small variant: 16 pages of eight bytes, 7-bit word address
// - large variant: 32 pages of eight bytes, 8-bit word address
// - data line changes only while the serial clock is low
// - data line change while clock high is start or stop, not data
// - falling data with clock high is start; begins a transfer
// - rising data with clock high is stop; ends the transaction
// - stop after a read sequence puts the device in standby
// - address and data move as serial 8-bit words both ways
// - device pulls data low in ninth clock to acknowledge each word; a data word that finds the fifo full is not acknowledged
// - standby at power-up and after stop once internal work ends
// - recovery: start, nine clocks, start, stop; then ready again
// - internal write cycle ends within 5 ms of the write stop
// - sample incoming bits on clock rise, shift outgoing on fall
// - data line driven open-drain only: pull low or release
`ifndef TWE_DEFINES_SVH
`define TWE_DEFINES_SVH

`define TWE_CLK_HZ 25000000
`define TWE_WR_TIME_MS 5
`define TWE_WR_CYCLES ((`TWE_WR_TIME_MS * `TWE_CLK_HZ) / 1000)
`define TWE_WR_CNT_W 17

`define TWE_CTRL_CODE 4'ha
`define TWE_SMALL_PAGES 16
`define TWE_LARGE_PAGES 32
`define TWE_SMALL_MASK 8'h7f
`define TWE_LARGE_MASK 8'hff
`define TWE_PAGE_SEL_MASK 8'hf8
`define TWE_PAGE_OFS_MASK 8'h07

`define TWE_CNT_ZERO 4'h0
`define TWE_CNT_ONE 4'h1
`define TWE_BYTE_LAST 4'h7
`define TWE_TX_LAST 4'h8

`define TWE_IDX_CMD 2'h0
`define TWE_IDX_ADDR 2'h1
`define TWE_IDX_DATA 2'h2

`define TWE_FIFO_DEPTH 8
`define TWE_SYNC_W 2

`endif

// ==== inc/twe_pkg.sv ====
// types shared by the two-wire eeprom bus core
package twe_pkg;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_RX,
        ST_RXD,
        ST_ACK,
        ST_TX,
        ST_TXA,
        ST_TXN,
        ST_WAIT,
        ST_WRITE
    } twe_state_e;

    typedef struct packed {
        logic scl;
        logic sda;
    } twe_pins_s;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } twe_wr_s;

endpackage : twe_pkg

// ==== rtl/twe_sync.sv ====
// two-stage synchroniser for pin inputs
`timescale 1ns/1ns
module twe_sync #(
    parameter int WIDTH = 2
) (
    input wire logic i_core_clk,
    input wire logic i_resetn,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++)
        begin : g_bit
            logic meta;
            logic stable;
            // resets high: an idle bus has both lines pulled up
            always_ff @(posedge i_core_clk)
            begin
                if (!i_resetn)
                begin
                    meta <= 1'b1;
                    stable <= 1'b1;
                end
                else
                begin
                    meta <= i_async[g];
                    stable <= meta;
                end
            end
            assign o_sync[g] = stable;
        end
    endgenerate
endmodule : twe_sync

// ==== rtl/twe_fifo.sv ====
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/1ns
module twe_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input wire logic i_core_clk,
    input wire logic i_resetn,
    input wire logic i_valid,
    output logic o_ready,
    input wire logic [WIDTH-1:0] i_data,
    output logic o_valid,
    input wire logic i_ready,
    output logic [WIDTH-1:0] o_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;

    wire full = (wr_ptr[AW] != rd_ptr[AW]) &&
        (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    wire empty = (wr_ptr == rd_ptr);
    wire do_wr = i_valid && !full;
    wire do_rd = i_ready && !empty;

    assign o_ready = !full;
    assign o_valid = !empty;
    assign o_data = mem[rd_ptr[AW-1:0]];

    always_ff @(posedge i_core_clk)
    begin
        if (do_wr)
            mem[wr_ptr[AW-1:0]] <= i_data;
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_resetn)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end
        else
        begin
            if (do_wr)
                wr_ptr <= wr_ptr + 1'b1;
            if (do_rd)
                rd_ptr <= rd_ptr + 1'b1;
        end
    end
endmodule : twe_fifo

// ==== rtl/twe_core.sv ====
// slave-side two-wire bus core of a small serial eeprom
`timescale 1ns/1ns
`include "twe_defines.svh"
module twe_core #(
    parameter bit LARGE_ARRAY = 1'b1,
    parameter int WRITE_CYCLES = `TWE_WR_CYCLES
) (
    input wire logic i_core_clk,
    input wire logic i_resetn,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_out,
    output logic o_sda_oe_n,
    output twe_pkg::twe_wr_s o_wr_data,
    output logic o_wr_valid,
    input wire logic i_wr_ready,
    input wire logic [7:0] i_rd_data,
    output logic [7:0] o_rd_addr,
    output logic o_rd_take,
    output logic o_standby,
    output logic o_write_busy
);
    import twe_pkg::*;

    twe_pins_s pins_raw;
    twe_pins_s pins_s;
    twe_state_e state;
    twe_state_e next_state;
    twe_wr_s wr_item;
    twe_wr_s next_item;

    logic scl_q;
    logic sda_q;
    logic [3:0] bit_cnt;
    logic [3:0] next_cnt;
    logic [7:0] rx_sh;
    logic [7:0] next_rx;
    logic [7:0] tx_sh;
    logic [7:0] next_tx;
    logic drive;
    logic next_drive;
    logic [1:0] byte_idx;
    logic [1:0] next_idx;
    logic rd_mode;
    logic next_rd;
    logic ack_q;
    logic next_ack;
    logic [7:0] word_addr;
    logic [7:0] next_addr;
    logic wr_pending;
    logic next_pend;
    logic [`TWE_WR_CNT_W-1:0] wr_cnt;
    logic [`TWE_WR_CNT_W-1:0] next_wcnt;
    logic rd_take;
    logic next_take;
    logic push;
    logic next_push;
    logic fifo_ready;
    logic [$bits(twe_wr_s)-1:0] fifo_q;

    // both pins cross into the core clock before any logic looks at them
    assign pins_raw.scl = i_scl;
    assign pins_raw.sda = i_sda;

    twe_sync #(.WIDTH(`TWE_SYNC_W)) u_sync (
        .i_core_clk(i_core_clk),
        .i_resetn(i_resetn),
        .i_async(pins_raw),
        .o_sync(pins_s)
    );

    // edges and bus conditions from the synchronised pins
    wire scl_s = pins_s.scl;
    wire sda_s = pins_s.sda;
    wire scl_rise = scl_s && !scl_q;
    wire scl_fall = !scl_s && scl_q;
    wire scl_high = scl_s && scl_q;
    wire start_det = scl_high && sda_q && !sda_s;
    wire stop_det = scl_high && !sda_q && sda_s;

    // word address width follows the array variant
    wire [7:0] addr_mask = LARGE_ARRAY ? `TWE_LARGE_MASK : `TWE_SMALL_MASK;
    wire [7:0] rx_byte = {rx_sh[6:0], sda_s};
    wire last_bit = (bit_cnt == `TWE_BYTE_LAST);
    wire is_cmd = (byte_idx == `TWE_IDX_CMD);
    wire is_addr = (byte_idx == `TWE_IDX_ADDR) && !rd_mode;
    wire is_data = (byte_idx == `TWE_IDX_DATA) && !rd_mode;
    wire cmd_ok = (rx_byte[7:4] == `TWE_CTRL_CODE);
    // a full fifo refuses the word: no acknowledge, master sees a nack
    wire byte_ok = is_cmd ? cmd_ok : (is_addr || (is_data && fifo_ready));
    wire load_now = scl_fall &&
        ((state == ST_ACK && rd_mode) || state == ST_TXN);
    // write: offset wraps inside the page, read: whole array wraps
    wire [7:0] page_next = (word_addr & `TWE_PAGE_SEL_MASK) |
        ((word_addr + 8'h01) & `TWE_PAGE_OFS_MASK);
    wire [7:0] read_next = (word_addr + 8'h01) & addr_mask;
    wire wr_done = (wr_cnt == `TWE_WR_CNT_W'(WRITE_CYCLES - 1));
    wire bus_live = (state != ST_WRITE);

    always_comb
    begin
        next_state = state;
        next_cnt = bit_cnt;
        next_rx = rx_sh;
        next_tx = tx_sh;
        next_drive = drive;
        next_idx = byte_idx;
        next_rd = rd_mode;
        next_ack = ack_q;
        next_addr = word_addr;
        next_pend = wr_pending;
        next_wcnt = wr_cnt;
        next_item = wr_item;
        next_take = 1'b0;
        next_push = 1'b0;
        case (state)
            ST_IDLE:
            begin
                next_drive = 1'b0;
            end
            ST_RX:
            begin
                if (scl_rise)
                begin
                    next_rx = rx_byte;
                    next_cnt = bit_cnt + `TWE_CNT_ONE;
                    if (last_bit)
                    begin
                        next_state = ST_RXD;
                        next_ack = byte_ok;
                        if (is_cmd)
                            next_rd = rx_byte[0];
                        if (is_addr)
                            next_addr = rx_byte & addr_mask;
                        if (is_data && fifo_ready)
                        begin
                            next_push = 1'b1;
                            next_pend = 1'b1;
                            next_item.addr = word_addr;
                            next_item.data = rx_byte;
                            next_addr = page_next;
                        end
                        if (byte_idx != `TWE_IDX_DATA)
                            next_idx = byte_idx + 2'h1;
                    end
                end
            end
            ST_RXD:
            begin
                if (scl_fall)
                begin
                    // acknowledge pull-down starts on the low after bit 8
                    next_drive = ack_q;
                    next_state = ack_q ? ST_ACK : ST_WAIT;
                end
            end
            ST_ACK:
            begin
                if (scl_fall)
                begin
                    next_drive = 1'b0;
                    next_cnt = `TWE_CNT_ZERO;
                    if (!rd_mode)
                        next_state = ST_RX;
                end
            end
            ST_TX:
            begin
                if (scl_fall)
                begin
                    if (bit_cnt == `TWE_TX_LAST)
                    begin
                        next_drive = 1'b0;
                        next_state = ST_TXA;
                    end
                    else
                    begin
                        next_drive = !tx_sh[7];
                        next_tx = {tx_sh[6:0], 1'b0};
                        next_cnt = bit_cnt + `TWE_CNT_ONE;
                    end
                end
            end
            ST_TXA:
            begin
                if (scl_rise)
                    next_state = sda_s ? ST_WAIT : ST_TXN;
            end
            ST_TXN:
            begin
                next_drive = 1'b0;
            end
            ST_WAIT:
            begin
                next_drive = 1'b0;
            end
            ST_WRITE:
            begin
                // pins ignored until the internal cycle is over
                next_drive = 1'b0;
                next_wcnt = wr_cnt + `TWE_WR_CNT_W'(1);
                if (wr_done)
                begin
                    next_state = ST_IDLE;
                    next_pend = 1'b0;
                end
            end
            default:
            begin
                next_state = ST_IDLE;
                next_drive = 1'b0;
            end
        endcase
        // first bit of a read word goes out on the same falling edge
        if (load_now)
        begin
            next_tx = {i_rd_data[6:0], 1'b0};
            next_drive = !i_rd_data[7];
            next_take = 1'b1;
            next_addr = read_next;
            next_cnt = `TWE_CNT_ONE;
            next_state = ST_TX;
        end
        if (bus_live && start_det)
        begin
            next_state = ST_RX;
            next_cnt = `TWE_CNT_ZERO;
            next_rx = 8'h00;
            next_idx = `TWE_IDX_CMD;
            next_rd = 1'b0;
            next_drive = 1'b0;
            next_take = 1'b0;
        end
        else if (bus_live && stop_det)
        begin
            next_drive = 1'b0;
            next_cnt = `TWE_CNT_ZERO;
            next_take = 1'b0;
            next_wcnt = '0;
            // a read or an empty write drops straight into standby
            next_state = wr_pending ? ST_WRITE : ST_IDLE;
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_resetn)
        begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            state <= ST_IDLE;
            bit_cnt <= `TWE_CNT_ZERO;
            rx_sh <= 8'h00;
            tx_sh <= 8'h00;
            drive <= 1'b0;
            byte_idx <= `TWE_IDX_CMD;
            rd_mode <= 1'b0;
            ack_q <= 1'b0;
        end
        else
        begin
            scl_q <= scl_s;
            sda_q <= sda_s;
            state <= next_state;
            bit_cnt <= next_cnt;
            rx_sh <= next_rx;
            tx_sh <= next_tx;
            drive <= next_drive;
            byte_idx <= next_idx;
            rd_mode <= next_rd;
            ack_q <= next_ack;
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_resetn)
        begin
            word_addr <= 8'h00;
            wr_pending <= 1'b0;
            wr_cnt <= '0;
            wr_item <= '0;
            rd_take <= 1'b0;
            push <= 1'b0;
        end
        else
        begin
            word_addr <= next_addr;
            wr_pending <= next_pend;
            wr_cnt <= next_wcnt;
            wr_item <= next_item;
            rd_take <= next_take;
            push <= next_push;
        end
    end

    // received words wait here for the array programming side
    twe_fifo #(.WIDTH($bits(twe_wr_s)), .DEPTH(`TWE_FIFO_DEPTH)) u_fifo (
        .i_core_clk(i_core_clk),
        .i_resetn(i_resetn),
        .i_valid(push),
        .o_ready(fifo_ready),
        .i_data(wr_item),
        .o_valid(o_wr_valid),
        .i_ready(i_wr_ready),
        .o_data(fifo_q)
    );

    // open drain: only ever a low level, the enable does the work
    assign o_sda_out = 1'b0;
    assign o_sda_oe_n = !drive;
    assign o_wr_data = fifo_q;
    assign o_rd_addr = word_addr;
    assign o_rd_take = rd_take;
    assign o_standby = (state == ST_IDLE);
    assign o_write_busy = (state == ST_WRITE);

    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_resetn);
    sequence s_last_bit;
        state == ST_RX && scl_rise && last_bit;
    endsequence
    // the eighth clock falls within 64 core cycles of its rise, and the pull-down follows
    sequence s_ack_fall;
        state == ST_RXD && scl_fall && ack_q;
    endsequence
    a_line_open_drain: assert property (
        !o_sda_oe_n |-> o_sda_out == 1'b0 && drive)
        else $error("data line driven high or enable out of step");
    a_drive_on_fall: assert property (
        $changed(drive) |-> $past(scl_fall || start_det || stop_det)
            || $past(state) == ST_TXN || $past(state) == ST_WRITE
            || $past(state) == ST_IDLE || $past(state) == ST_WAIT)
        else $error("data line changed outside clock low");
    a_start_restart: assert property (
        bus_live && start_det |=> state == ST_RX && bit_cnt == 4'h0
            && byte_idx == `TWE_IDX_CMD && drive == 1'b0)
        else $error("start did not restart word reception");
    a_high_change_no_bit: assert property (
        bus_live && scl_high && (sda_q != sda_s) |=> bit_cnt == 4'h0)
        else $error("change while clock high counted as data");
    a_stop_standby: assert property (
        bus_live && stop_det && !wr_pending |=> o_standby && !drive)
        else $error("stop without pending write missed standby");
    a_stop_write: assert property (
        bus_live && stop_det && wr_pending |=> o_write_busy ##1
            o_write_busy && !o_standby)
        else $error("stop after write did not start internal cycle");
    a_ack_ninth: assert property (
        s_last_bit ##[1:64] s_ack_fall |=> !o_sda_oe_n && state == ST_ACK)
        else $error("no acknowledge pull-down in ninth clock");
    a_ack_release: assert property (
        state == ST_ACK && scl_fall && !rd_mode |=> o_sda_oe_n
            && state == ST_RX)
        else $error("acknowledge held past ninth clock");
    a_sample_rise: assert property (
        state == ST_RX && scl_rise |=> rx_sh[0] == $past(sda_s)
            && bit_cnt == $past(bit_cnt) + 4'h1)
        else $error("incoming bit not taken on clock rise");
    a_addr_width: assert property (
        (word_addr & ~addr_mask) == 8'h00)
        else $error("word address wider than the array variant");
    a_write_bound: assert property (
        o_write_busy |-> wr_cnt < `TWE_WR_CNT_W'(WRITE_CYCLES))
        else $error("internal write ran past its time");
    a_write_ends: assert property (
        o_write_busy && wr_done |=> o_standby && !wr_pending)
        else $error("internal write did not end into standby");
endmodule : twe_core

// ==== tb/twe_master.sv ====
// two-wire bus master model driving the serial clock and data pins
`timescale 1ns/1ns
module twe_master (
    input wire logic i_core_clk,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_low
);
    initial
    begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
    end

    // a quarter of the 320 ns serial clock is two core cycles
    task automatic q(input int n);
        repeat (2 * n) @(negedge i_core_clk);
    endtask : q

    // data moves mid-low, is read mid-high
    task automatic clk_bit(input logic b, output logic s);
        q(1);
        o_sda_low = !b;
        q(1);
        o_scl = 1'b1;
        q(1);
        s = i_sda;
        q(1);
        o_scl = 1'b0;
    endtask : clk_bit

    // also serves as repeated start from a low clock
    task automatic start();
        if (!o_scl)
        begin
            q(1);
            o_sda_low = 1'b0;
            q(1);
            o_scl = 1'b1;
            q(1);
        end
        o_sda_low = 1'b1;
        q(2);
        o_scl = 1'b0;
    endtask : start

    task automatic stop();
        q(1);
        o_sda_low = 1'b1;
        q(1);
        o_scl = 1'b1;
        q(2);
        o_sda_low = 1'b0;
        q(2);
    endtask : stop

    task automatic tx_byte(input logic [7:0] v, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            clk_bit(v[i], s);
        clk_bit(1'b1, ack);
    endtask : tx_byte

    // released line reads the pull-up unless the device pulls it
    task automatic rx_byte(input logic ack_lvl, output logic [7:0] v);
        logic s;
        for (int i = 7; i >= 0; i--)
            clk_bit(1'b1, v[i]);
        clk_bit(ack_lvl, s);
    endtask : rx_byte
endmodule : twe_master

// ==== tb/testbench.sv ====
// self-checking bench of the two-wire eeprom bus core
`timescale 1ns/1ns
module testbench;
    import twe_pkg::*;
    localparam int WC = 200;
    logic i_core_clk;
    logic i_resetn;
    logic scl;
    logic m_low;
    logic sda;
    logic o_sda_out;
    logic o_sda_oe_n;
    twe_wr_s o_wr_data;
    twe_wr_s ev;
    logic o_wr_valid;
    logic i_wr_ready;
    logic [7:0] o_rd_addr;
    logic o_rd_take;
    logic o_standby;
    logic o_write_busy;
    logic hold;
    logic prev_scl;
    logic prev_oe;
    logic ack;
    logic [7:0] a;
    logic [7:0] v;
    logic [31:0] rng;
    logic [31:0] rq;
    logic [7:0] mem [256];
    twe_wr_s expq [$];
    int fails;
    int checks_done;
    int busy_cnt;
    int take_cnt;

    // open-drain wire with pull-up
    assign sda = !(m_low || (!o_sda_oe_n && !o_sda_out));

    twe_master m (
        .i_core_clk(i_core_clk),
        .i_sda(sda),
        .o_scl(scl),
        .o_sda_low(m_low)
    );

    twe_core #(.LARGE_ARRAY(1'b1), .WRITE_CYCLES(WC)) uut (
        .i_core_clk(i_core_clk),
        .i_resetn(i_resetn),
        .i_scl(scl),
        .i_sda(sda),
        .o_sda_out(o_sda_out),
        .o_sda_oe_n(o_sda_oe_n),
        .o_wr_data(o_wr_data),
        .o_wr_valid(o_wr_valid),
        .i_wr_ready(i_wr_ready),
        .i_rd_data(mem[o_rd_addr]),
        .o_rd_addr(o_rd_addr),
        .o_rd_take(o_rd_take),
        .o_standby(o_standby),
        .o_write_busy(o_write_busy)
    );

    initial
    begin
        i_core_clk = 1'b0;
        forever #20 i_core_clk = ~i_core_clk;
    end

    function automatic logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction : xs

    task automatic rnd8(output logic [7:0] r);
        rng = xs(rng);
        r = rng[7:0];
    endtask : rnd8

    task automatic give_verdict();
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : give_verdict

    task automatic chk1(input string n, input logic e, input logic g);
        checks_done++;
        if (g !== e)
        begin
            fails++;
            $display("Error %s expected %b seen %b", n, e, g);
        end
    endtask : chk1

    task automatic chk8(input string n, input logic [7:0] e,
                        input logic [7:0] g);
        checks_done++;
        if (g !== e)
        begin
            fails++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk8

    task automatic chk16(input string n, input logic [15:0] e,
                         input logic [15:0] g);
        checks_done++;
        if (g !== e)
        begin
            fails++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk16

    // consumer stalls at random; a stalled fifo must refuse bytes
    always @(negedge i_core_clk)
    begin
        rq = xs(rq);
        i_wr_ready <= !hold && rq[0];
    end

    always @(posedge i_core_clk)
    begin
        if (i_resetn && o_wr_valid && i_wr_ready)
        begin
            ev = expq.pop_front();
            chk16("write entry", ev, o_wr_data);
            mem[ev.addr] = ev.data;
        end
        if (i_resetn && scl && prev_scl)
        begin
            chk1("sda held in clock high", prev_oe, o_sda_oe_n);
            chk1("sda drive value", 1'b0, o_sda_out);
        end
        if (o_write_busy)
            busy_cnt++;
        if (o_rd_take)
            take_cnt++;
        prev_scl <= scl;
        prev_oe <= o_sda_oe_n;
    end

    task automatic settle();
        int i;
        i = 0;
        while ((o_write_busy !== 1'b0 || o_wr_valid !== 1'b0) && i < 4000)
        begin
            @(negedge i_core_clk);
            i++;
        end
        repeat (4) @(negedge i_core_clk);
    endtask : settle

    task automatic cmd(input logic [7:0] c, input logic e);
        m.tx_byte(c, ack);
        chk1("ack", e, ack);
    endtask : cmd

    // page write of n bytes; bytes from index nk on must be refused
    task automatic wr_seq(input logic [7:0] ad, input int n, input int nk);
        logic [7:0] d;
        m.start();
        cmd(8'ha0, 1'b0);
        cmd(ad, 1'b0);
        for (int k = 0; k < n; k++)
        begin
            rnd8(d);
            // queue first: the fifo may pop the word during its ack clock
            if (k < nk)
                expq.push_back({ad[7:3], ad[2:0] + k[2:0], d});
            cmd(d, k >= nk);
        end
        hold = 1'b0;
        busy_cnt = 0;
        m.stop();
        m.start();
        cmd(8'ha0, 1'b1);
        m.stop();
        settle();
        chk8("write queue left", 8'h00, 8'(expq.size()));
        chk1("write time", 1'b1, busy_cnt <= WC && busy_cnt >= WC - 2);
        chk1("standby", 1'b1, o_standby);
        m.start();
        cmd(8'ha0, 1'b0);
        m.stop();
    endtask : wr_seq

    task automatic rd_seq(input logic [7:0] ad, input int n);
        m.start();
        cmd(8'ha0, 1'b0);
        cmd(ad, 1'b0);
        m.start();
        cmd(8'ha1, 1'b0);
        take_cnt = 0;
        for (int k = 0; k < n; k++)
        begin
            m.rx_byte(k == n - 1, v);
            chk8("read byte", mem[ad + k[7:0]], v);
        end
        chk8("read takes", n[7:0], take_cnt[7:0]);
        m.stop();
        repeat (6) @(negedge i_core_clk);
        chk1("standby", 1'b1, o_standby);
    endtask : rd_seq

    initial
    begin
        #1000000;
        fails++;
        give_verdict();
    end

    initial
    begin
        i_resetn = 1'b0;
        i_wr_ready = 1'b0;
        hold = 1'b0;
        prev_scl = 1'b1;
        prev_oe = 1'b1;
        fails = 0;
        checks_done = 0;
        busy_cnt = 0;
        take_cnt = 0;
        rng = 32'hbf264612;
        rq = 32'hbf264612;
        for (int i = 0; i < 256; i++)
            rnd8(mem[i]);
        repeat (12) @(negedge i_core_clk);
        i_resetn = 1'b1;
        repeat (4) @(negedge i_core_clk);
        chk1("standby", 1'b1, o_standby);
        chk1("sda enable", 1'b1, o_sda_oe_n);
        rnd8(a);
        wr_seq({a[7:3], 3'h6}, 4, 8);
        rd_seq({a[7:3], 3'h0}, 8);
        rd_seq(8'hfe, 3);
        rnd8(a);
        hold = 1'b1;
        wr_seq(a, 10, 8);
        rd_seq({a[7:3], 3'h0}, 8);
        m.start();
        cmd(8'h50, 1'b1);
        m.stop();
        rnd8(a);
        m.start();
        cmd(8'ha0, 1'b0);
        cmd(a, 1'b0);
        for (int i = 0; i < 4; i++)
            m.clk_bit(i[0], ack);
        m.start();
        cmd(8'ha1, 1'b0);
        m.rx_byte(1'b1, v);
        chk8("read after restart", mem[a], v);
        m.stop();
        m.start();
        for (int i = 0; i < 9; i++)
            m.clk_bit(1'b1, ack);
        m.start();
        m.stop();
        repeat (6) @(negedge i_core_clk);
        chk1("standby after recovery", 1'b1, o_standby);
        rd_seq(a, 2);
        give_verdict();
    end
endmodule : testbench
